//--- src/tbp_defs.svh
// offsets, reset values and rates of the transmit backplane port
`ifndef TBP_DEFS_SVH
`define TBP_DEFS_SVH
`define TBP_A_GLOBAL 8'h00
`define TBP_A_STATUS 8'h04
`define TBP_A_CFG0 8'h10
`define TBP_A_CFG1 8'h14
`define TBP_A_GAP0 8'h20
`define TBP_A_GAP1 8'h24
`define TBP_G_MUX 0
`define TBP_G_SHARED 1
`define TBP_GLOBAL_RST 2'h0
`define TBP_CFG_RST 24'h000000
`define TBP_GAP_RST 24'h000000
`define TBP_SYS_KHZ 100000
`define TBP_T1_KHZ 1544
`define TBP_NCO_MOD 17'(`TBP_SYS_KHZ)
`define TBP_NCO_STEP 17'(`TBP_T1_KHZ)
`define TBP_FB_T1 11'h0C1
`define TBP_FB_E1 11'h100
`define TBP_FB_MUX 11'h400
`define TBP_STD_FBIT 8'hD0
`define TBP_E1_FBIT 8'h07
`endif

//--- src/tbp_pkg.sv
// types of the transmit backplane port
package tbp_pkg;
  typedef enum logic [1:0] {MAP_T1, MAP_STD, MAP_FILL, MAP_CONT} tbp_map_e;
  typedef struct packed {
    logic       slave;
    tbp_map_e   map;
    logic       payload_ctrl_enable;
    logic       gap8;
    logic       chanGap;
    logic       fbit_gap_enable;
    logic       fe;
    logic       de;
    logic       clock_speed_select;
    logic       dblEdge;
    logic       frame_pulse_type;
    logic       frame_pulse_invert;
    logic       errIe;
    logic [2:0] bitOffset;
    logic [6:0] chanOffset;
  } tbp_cfg_s;
  typedef struct packed {
    logic clk;
    logic fp;
    logic data;
    logic sig;
  } tbp_pin_in_s;
  typedef struct packed {
    logic clkOut;
    logic clkOe;
    logic fpOut;
    logic fpOe;
  } tbp_pin_out_s;
  typedef struct packed {
    logic       valid;
    logic       fbit;
    logic       data;
    logic       sig;
    logic [4:0] chan;
  } tbp_t1_s;
  typedef struct packed {
    logic       keep;
    logic       fbit;
    logic [4:0] chan;
    logic [2:0] bitNo;
  } tbp_map_s;
endpackage

//--- src/tbp_port.sv
// transmit backplane port: pin capture, rate mapping, offsets, apb registers
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"

// Contract
// - full master: continuous 1.544 MHz clock, F-bit and 24 channels taken
// - fractional master: 1.544 MHz clock suppressed in selected channels
// - fbit_gap_enable also suppresses the clock in the F-bit slot
// - whole-channel or bit-8 gapping, gapped data ignored, needs payload_ctrl_enable
// - slave accepts 1.544 or 2.048 Mb/s, 2.048 mapped by rate_map_select
// - standard map: slots 1-15, 17-25 to channels; slot 26 bit 1 is F
// - filler map: bit 8 is F, then three bytes kept, one dropped
// - continuous map: slots 1-24 to channels, bit 8 is F
// - slave clock and pulse from backplane, optionally shared from link 1
// - separate edge selects for frame pulse and for data and signaling
// - 2.048 slave: clock_speed_select picks single or double clock
// - double clock: edge select picks data edge, pulse on first edge
// - pulse marks every F-bit or multiframe start, polarity selectable
// - pulse spacing not a frame multiple sets error flag, optional interrupt
// - multiplexed bus byte-interleaved, links separated by channel offset
// - multiplexed bus clock and pulse common, single or double speed
// - multiplexed pulse refers to link 1 frames
// - bit and channel offset in all modes, signaling stays aligned
// - single clock: offset is N plus 8 times M clocks
// - double clock: offset is 2N plus 16M clocks
// - master drives clock and pulse, slave receives them
// - unmultiplexed 1.544/2.048 per link, multiplexed 8.192 split per link
module tbp_port #(
  parameter int MF_LEN = 24
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic [7:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire tbp_pkg::tbp_pin_in_s [1:0]   linkIn,
  input  wire tbp_pkg::tbp_pin_in_s         muxIn,
  output wire tbp_pkg::tbp_pin_out_s [1:0]  linkOut,
  output wire tbp_pkg::tbp_t1_s [1:0]       t1Out,
  output logic                              interruptOutN
);

  function automatic logic [10:0] frameBits(input tbp_pkg::tbp_map_e sel, input logic mux);
    frameBits = mux ? `TBP_FB_MUX : (sel == tbp_pkg::MAP_T1) ? `TBP_FB_T1 : `TBP_FB_E1;
  endfunction

  function automatic tbp_pkg::tbp_map_s mapBit(input tbp_pkg::tbp_map_e sel, input logic mux,
                                               input logic [10:0] rel);
    tbp_pkg::tbp_map_s r;
    logic [10:0]       t;
    logic [7:0]        e;
    logic [4:0]        k;
    r = '0;
    t = rel - 11'h001;
    // mux bus: every fourth byte belongs to this link
    e = mux ? {rel[9:5], rel[2:0]} : rel[7:0];
    k = e[7:3] - 5'h01;
    r.bitNo = e[2:0];
    case (sel)
      tbp_pkg::MAP_T1: begin
        r.keep  = 1'b1;
        r.fbit  = (rel == 11'h000);
        r.chan  = r.fbit ? 5'h00 : t[7:3] + 5'h01;
        r.bitNo = t[2:0];
      end
      tbp_pkg::MAP_STD: begin
        if (e[7:3] >= 5'h01 && e[7:3] <= 5'h0F) begin
          r.keep = 1'b1;
          r.chan = e[7:3];
        end else if (e[7:3] >= 5'h11 && e[7:3] <= 5'h19) begin
          r.keep = 1'b1;
          r.chan = e[7:3] - 5'h01;
        end else if (e == `TBP_STD_FBIT) begin
          r.keep = 1'b1;
          r.fbit = 1'b1;
        end
      end
      tbp_pkg::MAP_FILL: begin
        if (e == `TBP_E1_FBIT) begin
          r.keep = 1'b1;
          r.fbit = 1'b1;
        end else if (e[7:3] != 5'h00 && k[1:0] != 2'h3) begin
          r.keep = 1'b1;
          r.chan = {2'b00, k[4:2]} * 5'h03 + {3'b000, k[1:0]} + 5'h01;
        end
      end
      tbp_pkg::MAP_CONT: begin
        if (e == `TBP_E1_FBIT) begin
          r.keep = 1'b1;
          r.fbit = 1'b1;
        end else if (e[7:3] >= 5'h01 && e[7:3] <= 5'h18) begin
          r.keep = 1'b1;
          r.chan = e[7:3];
        end
      end
      default: r = '0;
    endcase
    // other slots belong to the other links on the bus
    if (mux && rel[4:3] != 2'h0) begin
      r.keep = 1'b0;
      r.fbit = 1'b0;
    end
    mapBit = r;
  endfunction

  // apb slave, zero wait states
  logic [1:0]              global_r;
  logic [1:0]              errFlag_r;
  logic [23:0]             cfgRaw_r [2];
  logic [23:0]             gapMask_r [2];
  logic [31:0]             prdata_r;
  logic [1:0]              errEv;
  tbp_pkg::tbp_cfg_s [1:0] cfg;

  wire wrEn     = psel && penable && pwrite;
  wire hitGlob  = (paddr == `TBP_A_GLOBAL);
  wire hitStat  = (paddr == `TBP_A_STATUS);
  wire hitCfg0  = (paddr == `TBP_A_CFG0);
  wire hitCfg1  = (paddr == `TBP_A_CFG1);
  wire hitGap0  = (paddr == `TBP_A_GAP0);
  wire hitGap1  = (paddr == `TBP_A_GAP1);
  wire hitAny   = hitGlob | hitStat | hitCfg0 | hitCfg1 | hitGap0 | hitGap1;
  wire [1:0] clrMask = (wrEn && hitStat) ? pwdata[1:0] : 2'h0;
  wire [31:0] rdMux = hitGlob ? {30'h0, global_r} :
                      hitStat ? {30'h0, errFlag_r} :
                      hitCfg0 ? {8'h00, cfgRaw_r[0]} :
                      hitCfg1 ? {8'h00, cfgRaw_r[1]} :
                      hitGap0 ? {8'h00, gapMask_r[0]} :
                      hitGap1 ? {8'h00, gapMask_r[1]} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign prdata  = prdata_r;
  assign cfg[0]  = tbp_pkg::tbp_cfg_s'(cfgRaw_r[0]);
  assign cfg[1]  = tbp_pkg::tbp_cfg_s'(cfgRaw_r[1]);

  wire muxEn     = global_r[`TBP_G_MUX];
  // sharing only when both links are slaves
  wire sharedEff = global_r[`TBP_G_SHARED] && cfg[0].slave && cfg[1].slave && !muxEn;

  assign interruptOutN = !(|(errFlag_r & {cfg[1].errIe, cfg[0].errIe}));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_r     <= `TBP_GLOBAL_RST;
      errFlag_r    <= 2'h0;
      cfgRaw_r[0]  <= `TBP_CFG_RST;
      cfgRaw_r[1]  <= `TBP_CFG_RST;
      gapMask_r[0] <= `TBP_GAP_RST;
      gapMask_r[1] <= `TBP_GAP_RST;
      prdata_r     <= 32'h0;
    end else if (ce) begin
      // a new error wins over a clear in the same cycle
      errFlag_r <= errEv | (errFlag_r & ~clrMask);
      if (psel && !penable) begin
        prdata_r <= rdMux;
      end
      if (wrEn && hitGlob) begin
        global_r <= pwdata[1:0];
      end
      if (wrEn && hitCfg0) begin
        cfgRaw_r[0] <= pwdata[23:0];
      end
      if (wrEn && hitCfg1) begin
        cfgRaw_r[1] <= pwdata[23:0];
      end
      if (wrEn && hitGap0) begin
        gapMask_r[0] <= pwdata[23:0];
      end
      if (wrEn && hitGap1) begin
        gapMask_r[1] <= pwdata[23:0];
      end
    end
  end

  // pin synchronisers; first stage read by the second only
  logic [11:0] syncA_r;
  logic [11:0] syncB_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 12'h000;
      syncB_r <= 12'h000;
    end else if (ce) begin
      syncA_r <= {muxIn, linkIn[1], linkIn[0]};
      syncB_r <= syncA_r;
    end
  end

  tbp_pkg::tbp_pin_in_s [1:0] linkS;
  tbp_pkg::tbp_pin_in_s       muxS;
  assign linkS[0] = tbp_pkg::tbp_pin_in_s'(syncB_r[3:0]);
  assign linkS[1] = tbp_pkg::tbp_pin_in_s'(syncB_r[7:4]);
  assign muxS     = tbp_pkg::tbp_pin_in_s'(syncB_r[11:8]);

  // 1.544 MHz master clock from a phase accumulator
  logic [16:0] nco_r;
  wire  [16:0] ncoSum = nco_r + `TBP_NCO_STEP;
  wire         ncoLvl = (nco_r < (`TBP_NCO_MOD >> 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nco_r <= 17'h00000;
    end else if (ce) begin
      nco_r <= (ncoSum >= `TBP_NCO_MOD) ? ncoSum - `TBP_NCO_MOD : ncoSum;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gLink
    logic               prevClk_r;
    logic               fpPrev_r;
    logic               pend_r;
    logic               phase_r;
    logic               started_r;
    logic [10:0]        pos_r;
    logic [4:0]         mf_r;
    logic               clkOut_r;
    logic               fpOut_r;
    tbp_pkg::tbp_t1_s   t1_r;
    tbp_pkg::tbp_map_s  m;

    // master drives clock and pulse, slave receives them
    wire isMaster = !cfg[g].slave && !muxEn;
    wire tbp_pkg::tbp_pin_in_s src = muxEn ? muxS :
                                     ((g == 1) && sharedEff) ? linkS[0] : linkS[g];
    wire tbp_pkg::tbp_map_e sel = isMaster ? tbp_pkg::MAP_T1 : cfg[g].map;
    wire srcClk   = isMaster ? ncoLvl : src.clk;
    // frame length follows the backplane rate
    wire [10:0] fb = frameBits(sel, muxEn);
    wire rise     = srcClk && !prevClk_r;
    wire fall     = !srcClk && prevClk_r;
    wire feEdge   = cfg[g].fe ? rise : fall;
    wire deEdge   = cfg[g].de ? rise : fall;
    wire sameEdge = (cfg[g].fe == cfg[g].de);
    wire fpAct    = src.fp ^ cfg[g].frame_pulse_invert;
    wire fpHit    = !isMaster && feEdge && fpAct && !fpPrev_r;
    wire start    = deEdge && (pend_r || (sameEdge && fpHit));
    // double clock only at the 2.048 or bus rate
    wire dbl      = cfg[g].clock_speed_select && (sel != tbp_pkg::MAP_T1);
    // pulse edge counts as the first edge of a bit
    wire phaseEff = start ? 1'b0 : phase_r;
    wire take     = deEdge && (!dbl || (phaseEff == cfg[g].dblEdge));
    wire [10:0] idx   = start ? 11'h000 : pos_r;
    // offset in bits; double clock doubles the clocks per bit
    wire [10:0] delay = {1'b0, cfg[g].chanOffset, 3'b000} + {8'h00, cfg[g].bitOffset};
    wire [11:0] diff  = {1'b0, idx} - {1'b0, delay};
    // frame start lags the pulse by the offset
    wire [10:0] rel   = diff[11] ? diff[10:0] + fb : diff[10:0];
    assign m = mapBit(sel, muxEn, rel);
    wire [4:0]  chIdx = m.chan - 5'h01;
    // gapping only with payload control enabled
    wire channel_gap_select = isMaster && cfg[g].payload_ctrl_enable &&
               (m.fbit ? cfg[g].fbit_gap_enable :
                (gapMask_r[g][chIdx] && (cfg[g].chanGap || (cfg[g].gap8 && m.bitNo == 3'h7))));
    wire lastBit  = (idx == fb - 11'h001);

    // pulse must arrive exactly at a frame boundary
    assign errEv[g] = start && started_r && (pos_r != 11'h000);
    assign linkOut[g] = '{clkOut: clkOut_r, clkOe: isMaster, fpOut: fpOut_r, fpOe: isMaster};
    assign t1Out[g]   = t1_r;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        prevClk_r <= 1'b0;
        fpPrev_r  <= 1'b0;
        pend_r    <= 1'b0;
        phase_r   <= 1'b0;
        started_r <= 1'b0;
        pos_r     <= 11'h000;
        mf_r      <= 5'h00;
      end else if (ce) begin
        prevClk_r <= srcClk;
        if (feEdge) begin
          fpPrev_r <= fpAct;
        end
        // pulse ahead of data waits for the data edge
        if (fpHit && !sameEdge) begin
          pend_r <= 1'b1;
        end else if (start) begin
          pend_r <= 1'b0;
        end
        if (deEdge) begin
          phase_r <= dbl ? !phaseEff : 1'b0;
        end
        started_r <= !isMaster && (started_r || start);
        if (take) begin
          pos_r <= lastBit ? 11'h000 : idx + 11'h001;
        end else if (start) begin
          pos_r <= 11'h000;
        end
        if (start) begin
          mf_r <= 5'h00;
        end else if (take && lastBit) begin
          mf_r <= (mf_r == 5'(MF_LEN - 1)) ? 5'h00 : mf_r + 5'h01;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        clkOut_r <= 1'b0;
        fpOut_r  <= 1'b0;
      end else if (ce) begin
        clkOut_r <= isMaster && ncoLvl && !channel_gap_select;
        if (feEdge) begin
          fpOut_r <= (pos_r == 11'h000 && (!cfg[g].frame_pulse_type || mf_r == 5'h00)) ^ cfg[g].frame_pulse_invert;
        end
      end
    end

    // mapped bit registered toward the framer
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        t1_r <= '0;
      end else if (ce) begin
        // data and signaling taken on the same edge
        t1_r.valid <= take && m.keep && !channel_gap_select;
        if (take) begin
          t1_r.fbit <= m.fbit;
          t1_r.data <= src.data;
          t1_r.sig  <= src.sig;
          t1_r.chan <= m.chan;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- test/tbp_port_properties.sv
// concurrent checks on the ports of the transmit backplane port
`timescale 1ns/1ps
`default_nettype none
module tbp_port_properties #(
  parameter int MF_LEN = 24
) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic [7:0]                  paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire tbp_pkg::tbp_pin_out_s [1:0] linkOut,
  input wire tbp_pkg::tbp_t1_s [1:0]      t1Out,
  input wire logic                        interruptOutN
);
  wire acc    = psel & penable;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24};
  wire wrGlob = acc & pwrite & (paddr == 8'h00);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  pready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
  err_cause_a: assert property (pslverr |-> acc && !mapped) else $error("error without cause");
  err_rdata_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped read data");
  rdata_hold_a: assert property (acc |=> $stable(prdata)) else $error("read data moved in access");
  slave_release_a: assert property (acc && pwrite && paddr == 8'h10 && pwdata[23] |=>
    !linkOut[0].clkOe && !linkOut[0].fpOe) else $error("slave link still drives");
  mux_release_a: assert property (wrGlob && pwdata[0] |=> !linkOut[1].clkOe && !linkOut[1].fpOe)
    else $error("mux mode link still drives");
  valid_pulse_a: assert property (t1Out[0].valid |=> !t1Out[0].valid) else $error("valid wider than one");
  fbit_chan_a: assert property (t1Out[0].valid |-> (t1Out[0].fbit ? t1Out[0].chan == 5'h00
    : t1Out[0].chan inside {[5'h01:5'h18]})) else $error("channel number out of frame");
  master_clock_a: assert property ($rose(linkOut[1].clkOut) && linkOut[1].clkOe |=>
    (linkOut[1].clkOut || !linkOut[1].clkOe)[*8] ##[20:29] !linkOut[1].clkOut) else $error("master clock rate");
  cover property (t1Out[0].valid && t1Out[0].fbit);
  cover property (acc && !mapped);
  cover property (!interruptOutN);
endmodule
bind tbp_port tbp_port_properties #(.MF_LEN(MF_LEN)) u_tbp_port_properties (.clk(clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .linkOut(linkOut), .t1Out(t1Out), .interruptOutN(interruptOutN));
`default_nettype wire

//--- test/tbp_backplane_model.sv
// backplane model: slave clock, frame pulse, data and signaling of one link
`timescale 1ns/1ps
`default_nettype none
module tbp_backplane_model (
  output var tbp_pkg::tbp_pin_in_s pins
);
  initial pins = '0;
  function automatic logic pat(input int i);
    return i[0] ^ i[1] ^ i[3] ^ i[6];
  endfunction
  // backplane supplies clock, pulse
  // clock stands still between frames, pulse high over bit 0
  task automatic send(input int len);
    for (int i = 0; i < len; i++) begin
      pins.fp = (i == 0);
      pins.data = pat(i);
      pins.sig = ~pat(i);
      #62.5 pins.clk = 1'b1;
      #62.5 pins.clk = 1'b0;
    end
    pins.fp = 1'b0;
    // released lines flip, never hold a stale value
    pins.data = ~pins.data;
    pins.sig = ~pins.sig;
  endtask
endmodule
`default_nettype wire

//--- test/tb_tbp_port.sv
// self-checking bench of the transmit backplane port
`timescale 1ns/1ps
`default_nettype none
module tb_tbp_port;
  logic                        clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        ce = 1'b1;
  tbp_pkg::tbp_pin_in_s        link1Pins = '0;
  tbp_pkg::tbp_pin_in_s        muxPins = '0;
  int                          n1 = 0;
  logic [7:0]                  paddr = 8'h00;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [31:0]                 pwdata = 32'h0;
  wire  [31:0]                 prdata;
  wire                         pready;
  wire                         pslverr;
  wire                         interruptOutN;
  tbp_pkg::tbp_pin_in_s        slavePins;
  wire tbp_pkg::tbp_pin_out_s [1:0] linkOut;
  wire tbp_pkg::tbp_t1_s [1:0] t1Out;
  logic [31:0]                 rd;
  logic                        er;
  logic [7:0]                  chB [0:24];
  int                          chN [0:24];
  logic                        fDat;
  int                          fN;
  int                          n_errors = 0;
  int                          checks = 0;
  int                          cyc = 0;
  int                          n;
  logic                        prev;
  int idxA [4] = '{1, 8, 8, 8};
  int chX [4] = '{24, 16, 4, 24};
  int idxX [4] = '{185, 136, 40, 192};
  int fIdx [4] = '{0, 208, 7, 7};
  int len [4] = '{193, 256, 256, 256};
  always #5 clk = ~clk;
  tbp_port #(.MF_LEN(24)) u_tbp_port (.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linkIn({link1Pins, slavePins}), .muxIn(muxPins), .linkOut(linkOut), .t1Out(t1Out),
    .interruptOutN(interruptOutN));
  tbp_backplane_model u_tbp_backplane_model (.pins(slavePins));
  // first eight bits of every channel and the first F-bit after a clear
  always @(posedge clk) begin
    if (t1Out[1].valid === 1'b1) n1++;
    if (t1Out[0].valid === 1'b1) begin
      if (t1Out[0].fbit === 1'b1) begin
        if (fN == 0) fDat = t1Out[0].data;
        fN++;
      end else if (t1Out[0].chan <= 5'h18 && chN[t1Out[0].chan] < 8) begin
        chB[t1Out[0].chan] = {chB[t1Out[0].chan][6:0], t1Out[0].data};
        chN[t1Out[0].chan]++;
      end
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task conclude;
    $display("tests ended: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // only the bench timeout ends a wait for pready
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write reach the outputs before callers look at them
    @(posedge clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0);
    check(rd, exp, what);
  endtask
  task clearMon;
    fN = 0;
    for (int i = 0; i < 25; i++) begin
      chN[i] = 0;
      chB[i] = 8'h00;
    end
  endtask
  function automatic logic [7:0] expByte(input int idx);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b = {b[6:0], u_tbp_backplane_model.pat(idx + k)};
    return b;
  endfunction
  // slave link, both edges rising, active-high pulse
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] b, input logic [6:0] c, input logic ie);
    return {8'h00, 1'b1, m, 4'h0, 2'h3, 4'h0, ie, b, c};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h10, 32'h0, "cfg0 reset");
    rdchk(8'h00, 32'h0, "global reset");
    check(linkOut[0].clkOe, 1'b1, "master clock enable");
    check(interruptOutN, 1'b1, "interrupt idle");
    apb(8'h20, 1'b1, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h00FFFFFF, "gap mask width");
    apb(8'h08, 1'b0, 32'h0);
    check({rd[30:0], er}, 32'h1, "unmapped read");
    ce <= 1'b0;
    apb(8'h24, 1'b1, 32'h00000055);
    ce <= 1'b1;
    rdchk(8'h24, 32'h0, "write frozen by ce");
    $display("test registers done");
    apb(8'h10, 1'b1, cfg(2'h0, 3'h0, 7'h00, 1'b1));
    check(linkOut[0].clkOe, 1'b0, "slave clock enable");
    repeat (2) u_tbp_backplane_model.send(193);
    apb(8'h04, 1'b1, 32'h3);
    u_tbp_backplane_model.send(193);
    rdchk(8'h04, 32'h0, "whole frame spacing");
    u_tbp_backplane_model.send(100);
    u_tbp_backplane_model.send(193);
    rdchk(8'h04, 32'h1, "short frame spacing");
    check(interruptOutN, 1'b0, "interrupt raised");
    apb(8'h04, 1'b1, 32'h1);
    rdchk(8'h04, 32'h0, "flag cleared");
    check(interruptOutN, 1'b1, "interrupt released");
    $display("test pulse spacing done");
    for (int m = 0; m < 4; m++) begin
      apb(8'h10, 1'b1, cfg(2'(m), 3'h0, 7'h00, 1'b0));
      clearMon();
      repeat (2) u_tbp_backplane_model.send(len[m]);
      check(chB[1], expByte(idxA[m]), "first channel");
      check(chB[chX[m]], expByte(idxX[m]), "later channel");
      check(fDat, u_tbp_backplane_model.pat(fIdx[m]), "F-bit");
    end
    $display("test rate maps done");
    apb(8'h10, 1'b1, cfg(2'h0, 3'h3, 7'h01, 1'b0));
    clearMon();
    repeat (2) u_tbp_backplane_model.send(193);
    check(fDat, u_tbp_backplane_model.pat(11), "offset F-bit");
    check(chB[1], expByte(12), "offset channel");
    $display("test offsets done");
    n = 0;
    prev = 1'b1;
    repeat (6477) begin
      @(posedge clk);
      if (linkOut[1].clkOut === 1'b1 && prev === 1'b0) n++;
      prev = linkOut[1].clkOut;
    end
    check(32'(n >= 99 && n <= 101), 32'h1, "master clock rate");
    // no zero rate map on either link while the bus is multiplexed
    apb(8'h10, 1'b1, cfg(2'h1, 3'h0, 7'h00, 1'b0));
    apb(8'h14, 1'b1, 32'h00200000);
    apb(8'h00, 1'b1, 32'h1);
    check(linkOut[1].clkOe, 1'b0, "mux releases link");
    apb(8'h00, 1'b1, 32'h0);
    check(linkOut[1].clkOe, 1'b1, "master again");
    $display("test master and mux done");
    // link 1 follows link 0 pins only while sharing is on
    apb(8'h14, 1'b1, cfg(2'h0, 3'h0, 7'h00, 1'b0));
    apb(8'h00, 1'b1, 32'h2);
    n1 = 0;
    u_tbp_backplane_model.send(193);
    check(n1, 193, "shared link bits");
    apb(8'h00, 1'b1, 32'h0);
    n1 = 0;
    u_tbp_backplane_model.send(193);
    check(n1, 0, "own idle link bits");
    $display("test shared clock done");
    conclude();
  end
endmodule
`default_nettype wire
